// ===== dor_pkg.sv
package dor_pkg;
  // Register window 0x14..0x19
  localparam int          REG_COUNT  = 6;
  localparam int          ADDR_WIDTH = 7;
  localparam logic [6:0]  REG_BASE   = 7'h14;
  localparam logic [6:0]  ADDR_CHAN_A_OFFSET_LOW  = 7'h14;
  localparam logic [6:0]  ADDR_CHAN_B_OFFSET_LOW  = 7'h15;
  localparam logic [6:0]  ADDR_CHAN_A_OFFSET_HIGH = 7'h16;
  localparam logic [6:0]  ADDR_CHAN_B_OFFSET_HIGH = 7'h17;
  localparam logic [6:0]  ADDR_POWER_SLEEP        = 7'h18;
  localparam logic [6:0]  ADDR_REFERENCE_SELECT   = 7'h19;
  // Index of each register inside the window
  localparam logic [2:0]  IDX_A_LOW  = 3'h0;
  localparam logic [2:0]  IDX_B_LOW  = 3'h1;
  localparam logic [2:0]  IDX_A_HIGH = 3'h2;
  localparam logic [2:0]  IDX_B_HIGH = 3'h3;
  localparam logic [2:0]  IDX_POWER  = 3'h4;
  localparam logic [2:0]  IDX_REF    = 3'h5;
  // Reset values and writable bits, index 5 on the left
  localparam logic [5:0][7:0] REG_RESET = {8'h00, 8'h83, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [5:0][7:0] REG_MASK  = {8'h04, 8'hCC, 8'hFF, 8'hF8, 8'hFF, 8'hFF};
  // Field positions
  localparam int OFFSET_WIDTH    = 13;
  localparam int OFFSET_HIGH_LSB = 3;
  localparam int DATA_WIDTH      = 16;
  localparam int FOUR_PIN_BIT    = 2;
  localparam int CLKPATH_A_BIT   = 1;
  localparam int CLKPATH_B_BIT   = 0;
  localparam int TSENSE_BIT      = 7;
  localparam int CLKRECV_BIT     = 6;
  localparam int SLEEP_B_BIT     = 3;
  localparam int SLEEP_A_BIT     = 2;
  localparam int EXTREF_BIT      = 2;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [ADDR_WIDTH-1:0] addr;
    logic [7:0]            wdata;
  } dor_reg_req_type;

  typedef struct packed {
    logic       valid;
    logic       hit;
    logic [7:0] data;
  } dor_reg_rsp_type;

  typedef struct packed {
    logic clkpath_off_a;
    logic clkpath_off_b;
    logic dac_sleep_a;
    logic dac_sleep_b;
    logic clock_receiver_sleep;
    logic strobe_receiver_sleep;
    logic tsense_enable;
    logic external_reference;
  } dor_power_type;

  localparam dor_power_type POWER_RESET = 8'h02;
endpackage

// ===== dor_sync2.sv
`timescale 1ns/1ns
module dor_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_one;

  // Two flops; only the second reads the first
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage_one <= '0;
      sync_out  <= '0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule

// ===== dor_offset_add.sv
`timescale 1ns/1ns
module dor_offset_add #(
  parameter int DATA_WIDTH   = 16,
  parameter int OFFSET_WIDTH = 13
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         in_valid,
  input  wire logic signed [DATA_WIDTH-1:0] in_data,
  input  wire logic [OFFSET_WIDTH-1:0]      offset,
  output logic                              out_valid,
  output logic signed [DATA_WIDTH-1:0]      out_data
);
  localparam logic signed [DATA_WIDTH:0] MAX_VAL = (DATA_WIDTH+1)'(2**(DATA_WIDTH-1) - 1);
  localparam logic signed [DATA_WIDTH:0] MIN_VAL = -MAX_VAL - (DATA_WIDTH+1)'(1);

  // Offset counts whole DAC LSBs, sign extended
  wire logic signed [DATA_WIDTH:0] offset_ext = (DATA_WIDTH+1)'(signed'(offset));
  wire logic signed [DATA_WIDTH:0] sum        = (DATA_WIDTH+1)'(in_data) + offset_ext;
  wire logic                       over       = sum > MAX_VAL;
  wire logic                       under      = sum < MIN_VAL;
  wire logic signed [DATA_WIDTH-1:0] next_out =
    over ? MAX_VAL[DATA_WIDTH-1:0] : (under ? MIN_VAL[DATA_WIDTH-1:0] : sum[DATA_WIDTH-1:0]);

  // Saturate rather than wrap: a wrap would flip the output polarity
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else
    begin
      out_valid <= in_valid;
      out_data  <= in_valid ? next_out : out_data;
    end
  end
endmodule

// ===== dor_config_regs.sv
//Contract
// R01 - Writing the channel A offset low register raises a sync that loads all four offset registers.
// R02 - Writes to the other offset registers only change stored values until the next sync.
// R03 - The host writes the channel A low register last when changing offsets.
// R04 - Channel A offset is register 0x16 bits 7:3 above register 0x14 bits 7:0.
// R05 - Channel B offset is register 0x17 bits 7:3 above register 0x15 bits 7:0.
// R06 - Offset values are added to channel data in units of one DAC LSB.
// R07 - The four-pin select bit makes the alarm pin a dedicated read-data output.
// R08 - Bit 1 of 0x17 sleeps the channel A clock path and bit 0 the channel B clock path.
// R09 - DAC sleep never stops the clock path; only chip power-down turns everything off.
// R10 - Bit 7 of 0x18 enables the temperature sensor and is set after reset.
// R11 - Bit 6 of 0x18 sleeps both the clock input receiver and the output strobe receiver.
// R12 - Bit 3 of 0x18 sleeps channel B and bit 2 sleeps channel A.
// R13 - Bit 2 of 0x19 selects the external reference when set, internal when clear.
// R14 - All registers reset to zero except 0x18 which resets to 0x83.
// R15 - Reserved bits keep their reset values and ignore writes.
`timescale 1ns/1ns
module dor_config_regs #(
  parameter int DATA_WIDTH   = 16,
  parameter int OFFSET_WIDTH = 13
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  dor_pkg::dor_reg_req_type          reg_req,
  output dor_pkg::dor_reg_rsp_type          reg_rsp,
  input  wire logic                         chip_power_down,
  input  wire logic                         alarm_level,
  input  wire logic                         sdo_data,
  input  wire logic                         sdo_drive,
  input  wire logic                         data_valid,
  input  wire logic signed [DATA_WIDTH-1:0] data_a,
  input  wire logic signed [DATA_WIDTH-1:0] data_b,
  output logic                              out_valid,
  output logic signed [DATA_WIDTH-1:0]      out_a,
  output logic signed [DATA_WIDTH-1:0]      out_b,
  output logic [OFFSET_WIDTH-1:0]           offset_a,
  output logic [OFFSET_WIDTH-1:0]           offset_b,
  output logic                              offset_sync,
  output logic                              four_pin_serial_select,
  output dor_pkg::dor_power_type            power,
  output logic                              alarm_serial_out_pin,
  output logic                              alarm_serial_out_pin_oe_n
);
  import dor_pkg::*;

  // Map an address onto {hit, index}; used by write and read
  function automatic logic [3:0] decode_addr(input logic [ADDR_WIDTH-1:0] addr);
    logic [ADDR_WIDTH-1:0] rel;
    rel = addr - REG_BASE;
    if (addr >= REG_BASE && rel < ADDR_WIDTH'(REG_COUNT))
      decode_addr = {1'b1, rel[2:0]};
    else
      decode_addr = 4'h0;
  endfunction

  logic [5:0][7:0] regs;
  logic            sync_req;
  logic            alarm_sync;

  // Request decoding
  wire logic [3:0] wr_dec = decode_addr(reg_req.addr);
  wire logic       wr_hit = reg_req.wr && wr_dec[3];
  wire logic       rd_hit = reg_req.rd && wr_dec[3];
  wire logic [2:0] req_idx = wr_dec[2:0];
  wire logic       low_a_write = wr_hit && req_idx == IDX_A_LOW;

  // Register bank; reserved bits are forced to reset values so they never move
  generate
    for (genvar i = 0; i < REG_COUNT; i++)
    begin : g_reg
      always_ff @(posedge clk)
      begin
        if (rst)
          regs[i] <= REG_RESET[i]; // R14
        else if (wr_hit && req_idx == 3'(i))
          regs[i] <= (reg_req.wdata & REG_MASK[i]) | (REG_RESET[i] & ~REG_MASK[i]); // R15
      end
    end
  endgenerate

  // Staged offset words, as they stand in the registers
  wire logic [OFFSET_WIDTH-1:0] staged_a =
    {regs[IDX_A_HIGH][7:OFFSET_HIGH_LSB], regs[IDX_A_LOW]}; // R04
  wire logic [OFFSET_WIDTH-1:0] staged_b =
    {regs[IDX_B_HIGH][7:OFFSET_HIGH_LSB], regs[IDX_B_LOW]}; // R05

  // Sync request is taken one edge after the low byte is stored,
  // so the load sees the new value of that write too
  always_ff @(posedge clk)
  begin
    if (rst)
      sync_req <= 1'b0;
    else
      sync_req <= low_a_write; // R01
  end

  // Active offsets move only on sync; other writes leave them alone
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      offset_a    <= '0;
      offset_b    <= '0;
      offset_sync <= 1'b0;
    end
    else
    begin
      offset_sync <= sync_req;
      if (sync_req)
      begin
        offset_a <= staged_a; // R01
        offset_b <= staged_b; // R02
      end
    end
  end

  // Read answer, one cycle after the request
  wire logic [7:0] rd_value = rd_hit ? regs[req_idx] : 8'h00;

  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rsp <= '0;
    else
    begin
      reg_rsp.valid <= reg_req.rd;
      reg_rsp.hit   <= rd_hit;
      reg_rsp.data  <= rd_value;
    end
  end

  // Power controls; the clock path ignores DAC sleep so the logic keeps a clock
  dor_power_type next_power;
  wire logic [7:0] pwr_reg = regs[IDX_POWER];
  wire logic [7:0] hib_reg = regs[IDX_B_HIGH];

  always_comb
  begin
    next_power.clkpath_off_a = hib_reg[CLKPATH_A_BIT] | chip_power_down; // R08 R09
    next_power.clkpath_off_b = hib_reg[CLKPATH_B_BIT] | chip_power_down; // R08 R09
    next_power.dac_sleep_a   = pwr_reg[SLEEP_A_BIT] | chip_power_down; // R12
    next_power.dac_sleep_b   = pwr_reg[SLEEP_B_BIT] | chip_power_down; // R12
    next_power.clock_receiver_sleep  = pwr_reg[CLKRECV_BIT] | chip_power_down; // R11
    next_power.strobe_receiver_sleep = pwr_reg[CLKRECV_BIT] | chip_power_down; // R11
    next_power.tsense_enable      = pwr_reg[TSENSE_BIT] & ~chip_power_down; // R10
    next_power.external_reference = regs[IDX_REF][EXTREF_BIT]; // R13
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      power <= POWER_RESET;
    else
      power <= next_power;
  end

  // Alarm comes from logic on another timing path, so synchronise it
  dor_sync2 #(
    .WIDTH (1)
  ) u_alarm_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (alarm_level),
    .sync_out (alarm_sync)
  );

  // Pin mux: four-pin mode hands the pin to serial read data
  wire logic next_pin  = hib_reg[FOUR_PIN_BIT] ? (sdo_drive & sdo_data) : alarm_sync; // R07
  wire logic next_oe_n = hib_reg[FOUR_PIN_BIT] ? ~sdo_drive : 1'b0; // R07

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alarm_serial_out_pin      <= 1'b0;
      alarm_serial_out_pin_oe_n <= 1'b1;
    end
    else
    begin
      alarm_serial_out_pin      <= next_pin;
      alarm_serial_out_pin_oe_n <= next_oe_n;
    end
  end

  assign four_pin_serial_select = regs[IDX_B_HIGH][FOUR_PIN_BIT];

  // Offset applied per channel in LSB units
  dor_offset_add #(
    .DATA_WIDTH   (DATA_WIDTH),
    .OFFSET_WIDTH (OFFSET_WIDTH)
  ) u_add_a (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (data_valid),
    .in_data   (data_a),
    .offset    (offset_a), // R06
    .out_valid (out_valid),
    .out_data  (out_a)
  );

  dor_offset_add #(
    .DATA_WIDTH   (DATA_WIDTH),
    .OFFSET_WIDTH (OFFSET_WIDTH)
  ) u_add_b (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (data_valid),
    .in_data   (data_b),
    .offset    (offset_b), // R06
    .out_valid (),
    .out_data  (out_b)
  );

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_low_write;
    reg_req.wr && reg_req.addr == ADDR_CHAN_A_OFFSET_LOW;
  endsequence

  sequence s_sync_load;
    ##2 offset_sync;
  endsequence

  a_sync_after_low: assert property ( // R01
    s_low_write |-> s_sync_load)
    else $error("offset sync missing after low byte write");

  a_offsets_hold: assert property ( // R02
    !sync_req |=> $stable(offset_a) && $stable(offset_b))
    else $error("active offset moved without sync");

  a_offset_a_map: assert property ( // R04
    offset_sync |-> offset_a == $past(staged_a))
    else $error("channel A offset not loaded from staged bits");

  a_offset_b_map: assert property ( // R05
    offset_sync |-> offset_b == $past(staged_b))
    else $error("channel B offset not loaded from staged bits");

  a_four_pin_drive: assert property ( // R07
    four_pin_serial_select && sdo_drive
      |=> !alarm_serial_out_pin_oe_n && alarm_serial_out_pin == $past(sdo_data))
    else $error("four-pin mode does not drive read data");

  a_three_pin_alarm: assert property ( // R07
    !four_pin_serial_select |=> !alarm_serial_out_pin_oe_n && alarm_serial_out_pin == $past(alarm_sync))
    else $error("three-pin mode does not carry alarm");

  a_clkpath_sleep: assert property ( // R08
    hib_reg[CLKPATH_A_BIT] |=> power.clkpath_off_a)
    else $error("channel A clock path not asleep");

  a_clkpath_kept: assert property ( // R09
    pwr_reg[SLEEP_A_BIT] && !hib_reg[CLKPATH_A_BIT] && !chip_power_down
      |=> power.dac_sleep_a && !power.clkpath_off_a)
    else $error("DAC sleep stopped its clock path");

  a_receiver_pair: assert property ( // R11
    power.clock_receiver_sleep == power.strobe_receiver_sleep)
    else $error("clock and strobe receivers disagree");

  a_dac_sleep_b: assert property ( // R12
    !chip_power_down |=> power.dac_sleep_b == $past(pwr_reg[SLEEP_B_BIT]))
    else $error("channel B sleep does not follow its bit");

  a_ref_select: assert property ( // R13
    ##1 power.external_reference == $past(regs[IDX_REF][EXTREF_BIT]))
    else $error("reference select does not follow its bit");

  a_reserved_fixed: assert property ( // R15
    (regs[IDX_POWER] & ~REG_MASK[IDX_POWER]) == (REG_RESET[IDX_POWER] & ~REG_MASK[IDX_POWER]))
    else $error("reserved power bits changed");

  a_reset_values: assert property ( // R14
    $past(rst) |-> regs[IDX_POWER] == 8'h83 && regs[IDX_A_LOW] == 8'h00)
    else $error("register reset value wrong");

  a_reset_zero: assert property ( // R14
    $past(rst) |-> regs[IDX_B_LOW] == 8'h00 && regs[IDX_A_HIGH] == 8'h00
      && regs[IDX_B_HIGH] == 8'h00 && regs[IDX_REF] == 8'h00)
    else $error("register not zero after reset");

  a_offset_reset: assert property ( // R14
    $past(rst) |-> offset_a == '0 && offset_b == '0)
    else $error("active offsets not zero after reset");

  // Offset registers other than the A low byte never raise a sync
  sequence s_other_offset_write;
    reg_req.wr && (reg_req.addr == ADDR_CHAN_B_OFFSET_LOW
      || reg_req.addr == ADDR_CHAN_A_OFFSET_HIGH || reg_req.addr == ADDR_CHAN_B_OFFSET_HIGH);
  endsequence

  sequence s_no_sync_load;
    ##2 !offset_sync;
  endsequence

  a_no_sync_other: assert property ( // R02
    s_other_offset_write |-> s_no_sync_load)
    else $error("offset sync raised by another offset write");

  a_sync_source: assert property ( // R01
    offset_sync |-> $past(low_a_write, 2))
    else $error("offset sync without a low byte write");

  // Power controls follow their bits unless the whole chip is powered down
  sequence s_running;
    !chip_power_down;
  endsequence

  a_clkpath_a_follow: assert property ( // R08
    s_running |=> power.clkpath_off_a == $past(hib_reg[CLKPATH_A_BIT]))
    else $error("channel A clock path does not follow its bit");

  a_clkpath_b_follow: assert property ( // R08
    s_running |=> power.clkpath_off_b == $past(hib_reg[CLKPATH_B_BIT]))
    else $error("channel B clock path does not follow its bit");

  a_dac_sleep_a: assert property ( // R12
    s_running |=> power.dac_sleep_a == $past(pwr_reg[SLEEP_A_BIT]))
    else $error("channel A sleep does not follow its bit");

  a_receiver_follow: assert property ( // R11
    s_running |=> power.clock_receiver_sleep == $past(pwr_reg[CLKRECV_BIT]))
    else $error("clock receiver sleep does not follow its bit");

  a_tsense_follow: assert property ( // R10
    s_running |=> power.tsense_enable == $past(pwr_reg[TSENSE_BIT]))
    else $error("temperature sensor enable does not follow its bit");

  // Full power-down is the only case where every part may stop
  a_power_down_all: assert property ( // R09
    chip_power_down |=> power.clkpath_off_a && power.clkpath_off_b && power.dac_sleep_a
      && power.dac_sleep_b && power.clock_receiver_sleep && !power.tsense_enable)
    else $error("power-down left a part running");

  a_four_pin_release: assert property ( // R07
    four_pin_serial_select && !sdo_drive |=> alarm_serial_out_pin_oe_n && !alarm_serial_out_pin)
    else $error("four-pin mode drives the pin while idle");

  // Read answers
  a_read_valid: assert property (
    reg_req.rd |=> reg_rsp.valid)
    else $error("read answer missing");

  a_unmapped_read: assert property (
    reg_req.rd && !wr_dec[3] |=> !reg_rsp.hit && reg_rsp.data == 8'h00)
    else $error("unmapped read answered with data");

  a_reserved_read: assert property ( // R15
    reg_req.rd && reg_req.addr == ADDR_POWER_SLEEP
      |=> (reg_rsp.data & ~REG_MASK[IDX_POWER]) == (REG_RESET[IDX_POWER] & ~REG_MASK[IDX_POWER]))
    else $error("reserved power bits read back wrong");
endmodule

// ===== dor_host_model.sv
`timescale 1ns/1ns
module dor_host_model (
  input  wire logic               clk,
  output dor_pkg::dor_reg_req_type req,
  input  dor_pkg::dor_reg_rsp_type rsp
);
  import dor_pkg::*;

  // Idle bus at start; after a request the lines show inverted values, not the last ones
  initial req = '0;

  // One write, held for exactly the edge that takes it
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // One read; the answer stands for one cycle after the taking edge
  task automatic read_reg(input logic [6:0] a, output dor_reg_rsp_type r);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    #1 r = rsp;
  endtask

  // Channel A low byte goes last so both offsets switch together
  task automatic set_offsets(input logic [7:0] al, bl, ah, bh);
    write_reg(ADDR_CHAN_B_OFFSET_LOW, bl);
    write_reg(ADDR_CHAN_A_OFFSET_HIGH, ah);
    write_reg(ADDR_CHAN_B_OFFSET_HIGH, bh);
    write_reg(ADDR_CHAN_A_OFFSET_LOW, al);
  endtask
endmodule

// ===== tb_dor_config_regs.sv
`timescale 1ns/1ns
module tb_dor_config_regs;
  import dor_pkg::*;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               chip_power_down = 1'b0;
  logic               alarm_level = 1'b0;
  logic               sdo_data = 1'b0;
  logic               sdo_drive = 1'b0;
  logic               data_valid = 1'b0;
  logic signed [15:0] data_a = '0;
  logic signed [15:0] data_b = '0;
  dor_reg_req_type    req;
  dor_reg_rsp_type    rsp;
  logic               out_valid, sync, four_pin, pin, pin_oe_n;
  logic signed [15:0] out_a, out_b;
  logic [12:0]        offset_a, offset_b;
  dor_power_type      power;
  int                 bad_count = 0;
  int                 check_count = 0;
  int                 cycles = 0;

  dor_config_regs dor_config_regs_i (
    .clk(clk), .rst(rst), .reg_req(req), .reg_rsp(rsp),
    .chip_power_down(chip_power_down), .alarm_level(alarm_level),
    .sdo_data(sdo_data), .sdo_drive(sdo_drive), .data_valid(data_valid),
    .data_a(data_a), .data_b(data_b), .out_valid(out_valid), .out_a(out_a),
    .out_b(out_b), .offset_a(offset_a), .offset_b(offset_b), .offset_sync(sync),
    .four_pin_serial_select(four_pin), .power(power),
    .alarm_serial_out_pin(pin), .alarm_serial_out_pin_oe_n(pin_oe_n)
  );

  dor_host_model dor_host_model_i (.clk(clk), .req(req), .rsp(rsp));

  // Clock and a hang guard well above the roughly 80 cycles the tests need
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic expect_reg(input logic [6:0] a, input logic [7:0] d, input logic hit);
    dor_reg_rsp_type r;
    dor_host_model_i.read_reg(a, r);
    check({r.valid, r.hit, r.data}, {1'b1, hit, d}, "read answer");
  endtask

  // Saturating sum with the offset sign-extended, in whole LSBs
  function automatic logic [15:0] sat_add(input logic signed [15:0] d, input logic [12:0] o);
    int s;
    s = int'(d) + int'($signed(o));
    if (s > 32767)
      s = 32767;
    if (s < -32768)
      s = -32768;
    return 16'(s);
  endfunction

  task automatic send(input logic signed [15:0] a, input logic signed [15:0] b);
    @(posedge clk);
    data_valid <= 1'b1;
    data_a <= a;
    data_b <= b;
    @(posedge clk);
    data_valid <= 1'b0;
    #1;
    check(16'(out_valid), 16'h0001, "sample valid");
    check(out_a, sat_add(a, 13'h155C), "channel a sample");
    check(out_b, sat_add(b, 13'h0933), "channel b sample");
  endtask

  // Power levels follow the register bits one cycle later
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic test_reset();
    for (int i = 0; i < REG_COUNT; i++)
      expect_reg(7'(REG_BASE + i), REG_RESET[i], 1'b1);
    expect_reg(7'h1A, 8'h00, 1'b0);
    check(16'(power), 16'(POWER_RESET), "power after reset");
  endtask

  task automatic test_offsets();
    int n;
    n = 0;
    dor_host_model_i.set_offsets(8'h5C, 8'h33, 8'hA8, 8'h48);
    while (sync !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(sync), 16'h0001, "sync strobe");
    check(16'(offset_a), 16'h155C, "offset a");
    check(16'(offset_b), 16'h0933, "offset b");
    send(16'sd100, -16'sd5);
    send(16'sh8000, 16'sh7FFF);
  endtask

  task automatic test_power();
    dor_host_model_i.write_reg(ADDR_CHAN_B_OFFSET_HIGH, 8'h07);
    dor_host_model_i.write_reg(ADDR_POWER_SLEEP, 8'hFF);
    dor_host_model_i.write_reg(ADDR_REFERENCE_SELECT, 8'hFF);
    settle();
    check(16'(power), 16'h00FF, "all sleeps set");
    check(16'(four_pin), 16'h0001, "four pin mode");
    check(16'(offset_b), 16'h0933, "offset b held");
    expect_reg(ADDR_CHAN_B_OFFSET_HIGH, 8'h07, 1'b1);
    expect_reg(ADDR_POWER_SLEEP, 8'hCF, 1'b1);
    expect_reg(ADDR_REFERENCE_SELECT, 8'h04, 1'b1);
    send(16'sd7, 16'sd9);
    dor_host_model_i.write_reg(ADDR_CHAN_B_OFFSET_HIGH, 8'h02);
    dor_host_model_i.write_reg(ADDR_POWER_SLEEP, 8'h04);
    dor_host_model_i.write_reg(ADDR_REFERENCE_SELECT, 8'h00);
    settle();
    check(16'(power), 16'h00A0, "channel a only asleep");
    @(posedge clk);
    chip_power_down <= 1'b1;
    settle();
    check(16'(power), 16'h00FC, "chip powered down");
    @(posedge clk);
    chip_power_down <= 1'b0;
    settle();
    check(16'(power), 16'h00A0, "chip powered up again");
  endtask

  // Read-data pin: owned by the serial engine in four-pin mode, alarm otherwise
  task automatic test_pin();
    dor_host_model_i.write_reg(ADDR_CHAN_B_OFFSET_HIGH, 8'h04);
    @(posedge clk);
    sdo_drive <= 1'b1;
    sdo_data <= 1'b1;
    settle();
    check({pin, pin_oe_n}, 2'b10, "pin drives read data");
    @(posedge clk);
    sdo_drive <= 1'b0;
    settle();
    check({pin, pin_oe_n}, 2'b01, "pin released");
    dor_host_model_i.write_reg(ADDR_CHAN_B_OFFSET_HIGH, 8'h00);
    @(posedge clk);
    alarm_level <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check({pin, pin_oe_n}, 2'b10, "pin shows alarm");
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    test_reset();
    test_offsets();
    test_power();
    test_pin();
    finish_test();
  end
endmodule
